// ==== sample_clock_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the clock generator control
`ifndef SAMPLE_CLOCK_REGS_SVH
`define SAMPLE_CLOCK_REGS_SVH

`define ADDR_W                6
`define ADDR_GEN2_MODE        6'h13
`define ADDR_GEN2_RATE        6'h14
`define ADDR_GEN2_PHASE       6'h15
`define ADDR_GEN3_MODE        6'h16

`define RST_GEN2_MODE         16'h00FF
`define RST_GEN2_RATE         16'hBB80
`define RST_GEN2_PHASE        16'h0000
`define RST_GEN3_MODE         16'h0000

`define BIT_REF_SELECT        15
`define BIT_VIDEO_LOCK        14
`define BIT_LOOP_GAIN         13
`define BIT_PLUS_200HZ        12
`define BIT_EIGHT_SEVENTHS    11
`define BIT_CONV_PIN_X128     10
`define BIT_PAL_SELECT        7
`define MSB_VIDEO_BASE        6
`define LSB_VIDEO_BASE        4
`define MSB_VIDEO_DIVISOR     3
`define BIT_SHIFT_DIRECTION   8
`define MSB_SHIFT_MAGNITUDE   7
`define MASK_GEN2_PHASE       16'h01FF
`define MASK_GEN3_MODE        16'hFCFF

`define RATE_W                17
`define BASE_48000            17'h0BB80
`define BASE_32000            17'h07D00
`define BASE_44100            17'h0AC44
`define BASE_29400            17'h072D8
`define BASE_44056            17'h0AC18

`define CLK_HZ                20000000
`define PHASE_STEP_HZ         3072000
`define PHASE_STEP_CYCLES     (`CLK_HZ / `PHASE_STEP_HZ)

`endif

// ==== sample_clock_pkg.sv ====
// Types shared by the clock generator control design
package sample_clock_pkg;
	typedef enum logic [1:0] {
		RESP_IDLE,
		RESP_WAIT_FRAME,
		RESP_WAIT_SLOT1
	} resp_state_e;
	typedef logic [15:0] ctrl_word_t;
endpackage

// ==== gen2_phase_engine.sv ====
// Incremental sample-phase advance and retard engine of the second generator
`timescale 1ns/10ps
`include "sample_clock_regs.svh"
module gen2_phase_engine
	import sample_clock_pkg::*;
#(
	parameter int STEP_CYCLES = `PHASE_STEP_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       clear,
	input  wire logic       load,
	input  wire logic       load_dir,
	input  wire logic [7:0] load_mag,
	input  wire logic       shift_allowed,
	output logic            dir_q,
	output logic [7:0]      mag_q,
	output logic            advance_q,
	output logic            retard_q
);
	localparam int CW = $clog2(STEP_CYCLES + 1);

	logic          dir_d;
	logic [7:0]    mag_d;
	logic          advance_d;
	logic          retard_d;
	logic [CW-1:0] tick_q;
	logic [CW-1:0] tick_d;

	always_comb begin
		dir_d     = dir_q;
		mag_d     = mag_q;
		tick_d    = tick_q;
		advance_d = 1'b0;
		retard_d  = 1'b0;
		if (clear) begin
			dir_d  = 1'b0;
			mag_d  = 8'h00;
			tick_d = '0;
		end else if (load) begin
			// A new value simply replaces any shift still outstanding
			dir_d  = load_dir; // [RQ11]
			mag_d  = load_mag;
			tick_d = '0;
		end else if (shift_allowed && mag_q != 8'h00) begin
			if (tick_q == CW'(STEP_CYCLES - 1)) begin
				tick_d    = '0;
				mag_d     = mag_q - 8'h01; // [RQ9]
				advance_d = ~dir_q; // [RQ7]
				retard_d  = dir_q; // [RQ7]
			end else begin
				tick_d = tick_q + CW'(1);
			end
		end else begin
			tick_d = '0;
		end
	end

	always_ff @(posedge clk) begin
		dir_q     <= dir_d;
		mag_q     <= mag_d;
		tick_q    <= tick_d;
		advance_q <= advance_d;
		retard_q  <= retard_d;
	end
endmodule

// ==== sample_clock_gen_ctrl.sv ====
// Control registers and rate selection of the second and third sample-clock generators
`timescale 1ns/10ps
`include "sample_clock_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RQ1: NTSC base code 100 gives 48 kHz only with sync raised by 1001/1000.
// RQ2: Second generator mode resets to 00FF, held and unwritable in reset or power-down.
// RQ3: Sample-rate word sets conversion rate at one hertz per count.
// RQ4: Software keeps the rate word between 0x0FA0 and 0xD2F0.
// RQ5: Sample-rate word resets to BB80, held and unwritable in reset or power-down.
// RQ6: Rate word is used only while the second generator is crystal referenced.
// RQ7: Direction bit 0 advances phase, 1 retards it.
// RQ8: Magnitude counts phase shift in 0.12 degree units.
// RQ9: Outstanding shift is applied one count at a time at 3.072 MHz; the code steps every 6 clocks of 20 MHz, about 3.333 MHz.
// RQ10: Phase read returns shift outstanding at frame start.
// RQ11: A new phase value replaces any shift still outstanding.
// RQ12: After a write, prior contents come back in slot 1 of next frame.
// RQ13: Phase register clears and locks in reset, power-down or generator disable.
// RQ14: Software writes zero to reserved phase bits.
// RQ15: Third generator crystal reference uses its rate, phase, bit-clock fields; video ignored.
// RQ16: Third generator mode register holds the documented field layout.
// RQ17: Sync-referenced second generator locks to sync and cannot be phase shifted.
// RQ18: Eight-sevenths bit scales the crystal rate by 8/7.
// RQ19: PAL video lock needs top modifier bit set and PAL line-rate sync.
// RQ20: PAL video rate is selected base divided by divisor field plus one.
// RQ21: Software keeps PAL divisors within the allowed set for each base.
module sample_clock_gen_ctrl
	import sample_clock_pkg::*;
#(
	parameter int PHASE_STEP_CYCLES = `PHASE_STEP_CYCLES
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                power_down_pin_n,
	input  wire logic                gen2_enable,
	input  wire logic                bus_master,
	input  wire logic                slot0_start,
	input  wire logic                frame_sync_in,
	input  wire logic                slot1_start,
	input  wire logic                ctrl_req,
	input  wire logic                ctrl_write,
	input  wire logic [`ADDR_W-1:0]  ctrl_addr,
	input  wire logic [15:0]         ctrl_wdata,
	output logic                     resp_valid_q,
	output ctrl_word_t               resp_data_q,
	output ctrl_word_t               gen2_mode_q,
	output ctrl_word_t               gen2_rate_q,
	output ctrl_word_t               gen3_mode_q,
	output logic [`RATE_W-1:0]       conv_rate_hz_q,
	output logic                     gen2_sync_ref_q,
	output logic                     gen2_video_active_q,
	output logic                     gen3_xtal_ref_q,
	output logic                     gen3_video_active_q,
	output logic                     phase_advance_q,
	output logic                     phase_retard_q,
	output logic                     gen2_shift_direction,
	output logic [7:0]               gen2_shift_magnitude
);
	////////////////////////////////////////////////////////////////////////////////
	// Lockout and write decode

	logic        lockout;
	logic        phase_lockout;
	logic        wr_mode;
	logic        wr_rate;
	logic        wr_phase;
	logic        wr_gen3;
	logic        frame_start;
	ctrl_word_t  phase_live;

	// Reset and power-down are one synchronous clear: registers sit at default and refuse writes
	assign lockout       = ~rst_n | ~power_down_pin_n; // [RQ2] [RQ5]
	assign phase_lockout = lockout | ~gen2_enable; // [RQ13]
	assign wr_mode       = ctrl_req & ctrl_write & (ctrl_addr == `ADDR_GEN2_MODE);
	assign wr_rate       = ctrl_req & ctrl_write & (ctrl_addr == `ADDR_GEN2_RATE);
	assign wr_phase      = ctrl_req & ctrl_write & (ctrl_addr == `ADDR_GEN2_PHASE);
	assign wr_gen3       = ctrl_req & ctrl_write & (ctrl_addr == `ADDR_GEN3_MODE);
	assign frame_start   = bus_master ? slot0_start : frame_sync_in; // [RQ10]

	////////////////////////////////////////////////////////////////////////////////
	// Phase engine; magnitude counts 0.12 degree steps of the sample clock

	gen2_phase_engine #(
		.STEP_CYCLES (PHASE_STEP_CYCLES)
	) u_phase (
		.clk           (clk),
		.clear         (phase_lockout), // [RQ13]
		.load          (wr_phase),
		.load_dir      (ctrl_wdata[`BIT_SHIFT_DIRECTION]), // [RQ7]
		.load_mag      (ctrl_wdata[`MSB_SHIFT_MAGNITUDE:0]), // [RQ8]
		.shift_allowed (~gen2_mode_q[`BIT_REF_SELECT]), // [RQ17]
		.dir_q         (gen2_shift_direction),
		.mag_q         (gen2_shift_magnitude),
		.advance_q     (phase_advance_q),
		.retard_q      (phase_retard_q)
	);

	// Reserved phase bits are not stored, so they always read back as zero
	assign phase_live = {7'h00, gen2_shift_direction, gen2_shift_magnitude};

	////////////////////////////////////////////////////////////////////////////////
	// Mode and rate registers

	ctrl_word_t gen2_mode_d;
	ctrl_word_t gen2_rate_d;
	ctrl_word_t gen3_mode_d;

	always_comb begin
		gen2_mode_d = gen2_mode_q;
		gen2_rate_d = gen2_rate_q;
		gen3_mode_d = gen3_mode_q;
		if (lockout) begin
			gen2_mode_d = `RST_GEN2_MODE; // [RQ2]
			gen2_rate_d = `RST_GEN2_RATE; // [RQ5]
			gen3_mode_d = `RST_GEN3_MODE;
		end else if (wr_mode) begin
			gen2_mode_d = ctrl_wdata;
		end else if (wr_rate) begin
			gen2_rate_d = ctrl_wdata;
		end else if (wr_gen3) begin
			gen3_mode_d = ctrl_wdata & `MASK_GEN3_MODE; // [RQ16]
		end
	end

	always_ff @(posedge clk) begin
		gen2_mode_q <= gen2_mode_d;
		gen2_rate_q <= gen2_rate_d;
		gen3_mode_q <= gen3_mode_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Conversion rate selection

	function automatic logic [`RATE_W-1:0] video_base(input logic pal, input logic [2:0] sel);
		logic [`RATE_W-1:0] b;
		b = '0;
		case (sel)
			3'h0: b = `BASE_48000;
			3'h1: b = `BASE_32000;
			3'h2: b = `BASE_44100;
			3'h3: b = `BASE_29400;
			// Nominal 48 kHz assumes the far end raised the NTSC sync rate
			3'h4: b = pal ? '0 : `BASE_48000; // [RQ1]
			3'h5: b = pal ? '0 : `BASE_44056;
			default: b = '0;
		endcase
		return b;
	endfunction

	logic [`RATE_W-1:0] conv_rate_d;
	logic [18:0]        scaled;
	logic [`RATE_W-1:0] base;
	logic [4:0]         divisor;
	logic               gen2_sync_ref_d;
	logic               gen2_video_active_d;
	logic               gen3_xtal_ref_d;
	logic               gen3_video_active_d;

	always_comb begin
		scaled  = {gen2_rate_q, 3'b000} / 19'h00007; // [RQ18]
		base    = video_base(gen2_mode_q[`BIT_PAL_SELECT],
			gen2_mode_q[`MSB_VIDEO_BASE:`LSB_VIDEO_BASE]); // [RQ19]
		divisor = {1'b0, gen2_mode_q[`MSB_VIDEO_DIVISOR:0]} + 5'h01;
		gen2_sync_ref_d     = gen2_mode_q[`BIT_REF_SELECT];
		gen2_video_active_d = gen2_mode_q[`BIT_REF_SELECT] & gen2_mode_q[`BIT_VIDEO_LOCK];
		conv_rate_d         = '0;
		if (!gen2_mode_q[`BIT_REF_SELECT]) begin
			// One count is one hertz with a 24.576 MHz crystal
			if (gen2_mode_q[`BIT_EIGHT_SEVENTHS]) begin
				conv_rate_d = scaled[`RATE_W-1:0]; // [RQ18]
			end else begin
				conv_rate_d = {1'b0, gen2_rate_q}; // [RQ3] [RQ6]
			end
		end else if (gen2_mode_q[`BIT_VIDEO_LOCK]) begin
			conv_rate_d = base / {12'h000, divisor}; // [RQ20]
		end
		// Normal sync lock leaves the rate to the loop, reported here as zero
		gen3_xtal_ref_d     = ~gen3_mode_q[`BIT_REF_SELECT]; // [RQ15]
		gen3_video_active_d = gen3_mode_q[`BIT_REF_SELECT] & gen3_mode_q[`BIT_VIDEO_LOCK]; // [RQ15]
	end

	always_ff @(posedge clk) begin
		conv_rate_hz_q      <= conv_rate_d;
		gen2_sync_ref_q     <= gen2_sync_ref_d; // [RQ17]
		gen2_video_active_q <= gen2_video_active_d;
		gen3_xtal_ref_q     <= gen3_xtal_ref_d;
		gen3_video_active_q <= gen3_video_active_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Readback in slot 1 of the frame after the request

	function automatic ctrl_word_t read_word(input logic [`ADDR_W-1:0] a,
		input ctrl_word_t ph, input ctrl_word_t m2, input ctrl_word_t r2,
		input ctrl_word_t m3);
		ctrl_word_t w;
		w = 16'h0000;
		if (a == `ADDR_GEN2_MODE) begin
			w = m2;
		end else if (a == `ADDR_GEN2_RATE) begin
			w = r2;
		end else if (a == `ADDR_GEN2_PHASE) begin
			w = ph;
		end else if (a == `ADDR_GEN3_MODE) begin
			w = m3;
		end
		return w;
	endfunction

	resp_state_e state_q;
	resp_state_e state_d;
	ctrl_word_t  phase_snap_q;
	ctrl_word_t  phase_snap_d;
	ctrl_word_t  pend_q;
	ctrl_word_t  pend_d;
	logic        resp_valid_d;
	ctrl_word_t  resp_data_d;

	always_comb begin
		state_d      = state_q;
		pend_d       = pend_q;
		resp_valid_d = 1'b0;
		resp_data_d  = resp_data_q;
		// Outstanding shift is caught at each frame start for later reads
		phase_snap_d = frame_start ? phase_live : phase_snap_q; // [RQ10]
		case (state_q)
			RESP_WAIT_FRAME: begin
				if (frame_start) begin
					state_d = RESP_WAIT_SLOT1;
				end
			end
			RESP_WAIT_SLOT1: begin
				if (slot1_start) begin
					state_d      = RESP_IDLE;
					resp_valid_d = 1'b1; // [RQ12]
					resp_data_d  = pend_q;
				end
			end
			default: begin
				state_d = RESP_IDLE;
			end
		endcase
		// A later request in the same frame takes the single return slot
		if (ctrl_req) begin
			state_d = RESP_WAIT_FRAME;
			pend_d  = read_word(ctrl_addr, ctrl_write ? phase_live : phase_snap_q,
				gen2_mode_q, gen2_rate_q, gen3_mode_q); // [RQ12] [RQ10]
		end
		if (!rst_n) begin
			state_d      = RESP_IDLE;
			resp_valid_d = 1'b0;
			pend_d       = 16'h0000;
			phase_snap_d = `RST_GEN2_PHASE;
			resp_data_d  = 16'h0000;
		end
	end

	always_ff @(posedge clk) begin
		state_q      <= state_d;
		pend_q       <= pend_d;
		phase_snap_q <= phase_snap_d;
		resp_valid_q <= resp_valid_d;
		resp_data_q  <= resp_data_d;
	end
endmodule

// ==== sample_clock_gen_ctrl_properties.sv ====
// Concurrent checks on the ports of the sample-clock generator control
`timescale 1ns/10ps
`include "sample_clock_regs.svh"
module clk_gen_checker
	import sample_clock_pkg::*;
#(
	parameter int PHASE_STEP_CYCLES = 6
) (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               power_down_pin_n,
	input wire logic               gen2_enable,
	input wire logic               ctrl_req,
	input wire logic               slot1_start,
	input wire logic               resp_valid_q,
	input wire ctrl_word_t         gen2_mode_q,
	input wire ctrl_word_t         gen2_rate_q,
	input wire ctrl_word_t         gen3_mode_q,
	input wire logic [`RATE_W-1:0] conv_rate_hz_q,
	input wire logic               gen2_sync_ref_q,
	input wire logic               gen3_xtal_ref_q,
	input wire logic               gen3_video_active_q,
	input wire logic               phase_advance_q,
	input wire logic               phase_retard_q,
	input wire logic               gen2_shift_direction,
	input wire logic [7:0]         gen2_shift_magnitude
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_pd_hold: assert property (!power_down_pin_n |=> gen2_mode_q == 16'h00FF &&
		gen2_rate_q == 16'hBB80 && gen3_mode_q == 16'h0000) else $error("power-down hold lost");
	a_phase_lock: assert property ((!gen2_enable || !power_down_pin_n) |=>
		gen2_shift_magnitude == 8'h00 && !gen2_shift_direction) else $error("phase not locked");
	a_rate_xtal: assert property (gen2_mode_q[15] == 1'b0 && gen2_mode_q[11] == 1'b0 |=>
		conv_rate_hz_q == {1'b0, $past(gen2_rate_q)}) else $error("rate word not used");
	a_rate_seven: assert property (gen2_mode_q[15] == 1'b0 && gen2_mode_q[11] |=>
		conv_rate_hz_q == 17'(({4'h0, $past(gen2_rate_q)} * 20'h8) / 20'h7))
		else $error("eight-sevenths rate wrong");
	a_pal_rate: assert property (gen2_mode_q[15:14] == 2'b11 && gen2_mode_q[7:4] == 4'h8 |=>
		conv_rate_hz_q == 17'h0BB80 / ({13'h0000, $past(gen2_mode_q[3:0])} + 17'h00001))
		else $error("video rate wrong");
	a_sync_freeze: assert property (gen2_mode_q[15] && !ctrl_req && gen2_enable &&
		power_down_pin_n |=> $stable(gen2_shift_magnitude) && gen2_sync_ref_q)
		else $error("shift moved under sync reference");
	a_step_count: assert property ((phase_advance_q || phase_retard_q) &&
		$past(gen2_enable && power_down_pin_n) |->
		gen2_shift_magnitude == $past(gen2_shift_magnitude) - 8'h01) else $error("step not counted");
	a_step_dir: assert property ((phase_advance_q || phase_retard_q) |->
		phase_retard_q == gen2_shift_direction && !(phase_advance_q && phase_retard_q))
		else $error("step direction wrong");
	a_answer_slot: assert property (resp_valid_q |-> $past(slot1_start))
		else $error("answer outside slot 1");
	a_gen3_ref: assert property (1'b1 |=> gen3_xtal_ref_q == !$past(gen3_mode_q[15]) &&
		gen3_video_active_q == &$past(gen3_mode_q[15:14])) else $error("gen3 reference wrong");
endmodule

bind sample_clock_gen_ctrl clk_gen_checker #(.PHASE_STEP_CYCLES(PHASE_STEP_CYCLES)) chk_i (.*);

// ==== frame_host_model.sv ====
// Host side frame timing: frame-start and slot 1 pulses
`timescale 1ns/10ps
module frame_host_model #(
	parameter int FRAME = 40
) (
	input  wire logic clk,
	input  wire logic bus_master,
	output logic      slot0_start,
	output logic      frame_sync_in,
	output logic      slot1_start
);
	int cnt = 0;
	initial {slot0_start, frame_sync_in, slot1_start} = 3'h0;
	// Driven on the falling edge so the block samples settled pulses
	always @(negedge clk) begin
		cnt = (cnt + 1) % FRAME;
		slot0_start = bus_master && cnt == 0;
		frame_sync_in = !bus_master && cnt == 0;
		slot1_start = cnt == 16;
	end
endmodule

// ==== tb.sv ====
// Self-checking bench for the sample-clock generator control
`timescale 1ns/10ps
`include "sample_clock_regs.svh"
module tb;
	import sample_clock_pkg::*;
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	logic               power_down_pin_n = 1'b1;
	logic               gen2_enable = 1'b1;
	logic               bus_master = 1'b1;
	logic               ctrl_req = 1'b0;
	logic               ctrl_write = 1'b0;
	logic [`ADDR_W-1:0] ctrl_addr = 6'h00;
	ctrl_word_t         ctrl_wdata = 16'h0000;
	logic               slot0_start, frame_sync_in, slot1_start, resp_valid_q, gen2_sync_ref_q;
	logic               gen2_video_active_q, gen3_xtal_ref_q, gen3_video_active_q;
	logic               phase_advance_q, phase_retard_q, gen2_shift_direction;
	logic [7:0]         gen2_shift_magnitude;
	ctrl_word_t         resp_data_q, gen2_mode_q, gen2_rate_q, gen3_mode_q;
	logic [`RATE_W-1:0] conv_rate_hz_q;
	int                 failures = 0;
	int                 compares = 0;
	int                 n_adv = 0;
	int                 n_ret = 0;

	always #25 clk = ~clk;
	frame_host_model host (.*);
	sample_clock_gen_ctrl dut (.*);
	always @(posedge clk) begin
		n_adv = n_adv + int'(phase_advance_q === 1'b1);
		n_ret = n_ret + int'(phase_retard_q === 1'b1);
	end

	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (failures == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic send(input logic w, input logic [5:0] a, input ctrl_word_t d);
		@(negedge clk);
		ctrl_req = 1'b1;
		ctrl_write = w;
		ctrl_addr = a;
		ctrl_wdata = d;
		@(negedge clk);
		ctrl_req = 1'b0;
	endtask

	// Each request made through here is checked against its answer, old contents for writes
	task automatic xfer(input logic w, input logic [5:0] a, input ctrl_word_t d, input ctrl_word_t e);
		send(w, a, d);
		repeat (200) begin
			@(posedge clk);
			#1;
			if (resp_valid_q === 1'b1) break;
		end
		if (resp_valid_q !== 1'b1) begin
			failures++;
			final_report();
		end
		chk("answer", e, resp_data_q);
	endtask

	task automatic drain();
		repeat (3000) begin
			@(negedge clk);
			if (gen2_shift_magnitude === 8'h00) break;
		end
		if (gen2_shift_magnitude !== 8'h00) begin
			failures++;
			final_report();
		end
		// The last step pulse is counted one edge after the magnitude reaches zero
		@(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("mode", 16'h00FF, gen2_mode_q);
		chk("rate", 16'hBB80, gen2_rate_q);
		chk("hz", 17'h0BB80, conv_rate_hz_q);
		xfer(1'b0, 6'h15, 16'h0000, 16'h0000);
		xfer(1'b0, 6'h3F, 16'h0000, 16'h0000);
	endtask

	task automatic t_rate();
		xfer(1'b1, 6'h14, 16'h0FA0, 16'hBB80);
		chk("hz", 17'h00FA0, conv_rate_hz_q);
		xfer(1'b1, 6'h13, 16'h0800, 16'h00FF);
		chk("hz", 17'h011DB, conv_rate_hz_q);
		xfer(1'b1, 6'h14, 16'hD2F0, 16'h0FA0);
		chk("hz", 17'h0F112, conv_rate_hz_q);
	endtask

	task automatic t_phase();
		n_ret = 0;
		xfer(1'b1, 6'h15, 16'h0105, 16'h0000);
		drain();
		chk("retard steps", 17'h00005, 17'(n_ret));
		n_adv = 0;
		xfer(1'b1, 6'h15, 16'h0003, 16'h0100);
		drain();
		chk("advance steps", 17'h00003, 17'(n_adv));
		send(1'b1, 6'h15, 16'h0040);
		repeat (8) @(negedge clk);
		n_adv = 0;
		n_ret = 0;
		send(1'b1, 6'h15, 16'h0102);
		chk("magnitude", 17'h00002, gen2_shift_magnitude);
		drain();
		chk("steps", 17'h00002, 17'(n_ret + n_adv * 16));
	endtask

	task automatic t_lock();
		@(negedge clk);
		gen2_enable = 1'b0;
		xfer(1'b1, 6'h15, 16'h0010, 16'h0000);
		chk("magnitude", 17'h00000, gen2_shift_magnitude);
		@(negedge clk);
		gen2_enable = 1'b1;
		power_down_pin_n = 1'b0;
		xfer(1'b1, 6'h14, 16'h1F40, 16'hBB80);
		chk("rate", 16'hBB80, gen2_rate_q);
		chk("mode", 16'h00FF, gen2_mode_q);
		@(negedge clk);
		power_down_pin_n = 1'b1;
	endtask

	task automatic t_video();
		xfer(1'b1, 6'h13, 16'hC083, 16'h00FF);
		chk("hz", 17'h02EE0, conv_rate_hz_q);
		chk("video", 17'h00001, gen2_video_active_q);
		// Far end is taken to run the raised NTSC line rate, so code 100 is 48 kHz
		xfer(1'b1, 6'h13, 16'hC041, 16'hC083);
		chk("hz", 17'h05DC0, conv_rate_hz_q);
		xfer(1'b1, 6'h15, 16'h0004, 16'h0000);
		chk("magnitude", 17'h00004, gen2_shift_magnitude);
		@(negedge clk);
		bus_master = 1'b0;
		xfer(1'b0, 6'h15, 16'h0000, 16'h0004);
		chk("sync ref", 17'h00001, gen2_sync_ref_q);
		xfer(1'b1, 6'h13, 16'h0000, 16'hC041);
		chk("hz", 17'h0BB80, conv_rate_hz_q);
		drain();
	endtask

	task automatic t_gen3();
		xfer(1'b1, 6'h16, 16'hFFFF, 16'h0000);
		chk("gen3", 16'hFCFF, gen3_mode_q);
		chk("gen3 xtal", 17'h00000, gen3_xtal_ref_q);
		chk("gen3 video", 17'h00001, gen3_video_active_q);
		xfer(1'b1, 6'h16, 16'h0000, 16'hFCFF);
		chk("gen3 xtal", 17'h00001, gen3_xtal_ref_q);
	endtask

	// Reset pulled in mid-run must restore the defaults over written values
	task automatic t_mid_reset();
		xfer(1'b1, 6'h14, 16'h1F40, 16'hBB80);
		@(negedge clk);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		chk("rate", 16'hBB80, gen2_rate_q);
		chk("mode", 16'h00FF, gen2_mode_q);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		chk("hz", 17'h0BB80, conv_rate_hz_q);
		xfer(1'b0, 6'h14, 16'h0000, 16'hBB80);
	endtask

	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		t_reset();
		t_rate();
		t_phase();
		t_lock();
		t_video();
		t_gen3();
		t_mid_reset();
		final_report();
	end
endmodule
